// >>> ptbf_pkg.sv
// Summary of operation
// - Processor warm reset never resets trace unit.
// - Every block holds at least one instruction.
// - At most one waypoint instruction per block.
// - Waypoint instruction is always last in block.
// - Exceptions occur only at block boundaries.
// - Block addresses are consecutive: start plus count.
// - Every speculative block ends resolved or canceled.
// - Resolve covers instructions that execute architecturally.
// - Cancel covers seen but unexecuted instructions.
// - Secure prohibited when debug off, self-hosted off.
// - Withdrawn Secure permission prohibits trace two cycles later.
// - Prohibited region traces no instructions or exceptions.
// - Address comparator never matches in prohibited region.
// - Cycle counter keeps counting through prohibited regions.
// - Prohibited region output reveals nothing about execution.
// - Leaving prohibited region with view emits trace-on unless a resolve or cancel takes that cycle.
// - Traced exception entering prohibited region still reported.
package ptbf_pkg;

   // -------------------------------------------------------------------
   // Widths and reset values.
   // -------------------------------------------------------------------
   localparam int PTBF_ADDR_W = 32;
   localparam int PTBF_CNT_W = 8;
   localparam int PTBF_TAG_W = 4;
   localparam int PTBF_EXC_W = 4;
   localparam int PTBF_CYC_W = 16;
   localparam logic [PTBF_CYC_W-1:0] PTBF_CYC_RST = 16'h0000;
   localparam logic [PTBF_ADDR_W-1:0] PTBF_ADDR_RST = 32'h0000_0000;
   localparam logic [PTBF_CNT_W-1:0] PTBF_CNT_ONE = 8'h01;

   // -------------------------------------------------------------------
   // Trace element kinds.
   // -------------------------------------------------------------------
   typedef enum logic [5:0] {
      PTBF_EL_BLOCK = 6'b00_0001,
      PTBF_EL_RESOLVE = 6'b00_0010,
      PTBF_EL_CANCEL = 6'b00_0100,
      PTBF_EL_EXCEPT = 6'b00_1000,
      PTBF_EL_TRACE_ON = 6'b01_0000,
      PTBF_EL_CYCLES = 6'b10_0000
   } ptbf_elem_t;

   // Returns high when an address lies inside the comparator window.
   function automatic logic ptbf_in_range(
      input logic [PTBF_ADDR_W-1:0] a,
      input logic [PTBF_ADDR_W-1:0] lo,
      input logic [PTBF_ADDR_W-1:0] hi
   );
      ptbf_in_range = (a >= lo) && (a <= hi);
   endfunction : ptbf_in_range

endpackage : ptbf_pkg

// >>> ptbf_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link from the processor pipeline into the trace block filter.
interface ptbf_if
   import ptbf_pkg::*;
   ();
   logic blk_valid;
   logic [PTBF_ADDR_W-1:0] blk_addr;
   logic [PTBF_CNT_W-1:0] blk_count;
   logic blk_waypoint;
   logic blk_spec;
   logic [PTBF_TAG_W-1:0] blk_tag;
   logic blk_prohibited;
   logic blk_secure;
   logic res_valid;
   logic res_cancel;
   logic [PTBF_TAG_W-1:0] res_tag;
   logic exc_valid;
   logic [PTBF_EXC_W-1:0] exc_type;
   logic exc_into_prohibited;
   logic exc_prohibited;

   modport cpu (
      output blk_valid, blk_addr, blk_count, blk_waypoint, blk_spec,
      output blk_tag, blk_prohibited, blk_secure,
      output res_valid, res_cancel, res_tag,
      output exc_valid, exc_type, exc_into_prohibited, exc_prohibited
   );
   modport trc (
      input blk_valid, blk_addr, blk_count, blk_waypoint, blk_spec,
      input blk_tag, blk_prohibited, blk_secure,
      input res_valid, res_cancel, res_tag,
      input exc_valid, exc_type, exc_into_prohibited, exc_prohibited
   );
endinterface : ptbf_if
`default_nettype wire

// >>> ptbf_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
// Processor side: turns retire requests into well formed blocks.
module ptbf_cpu_end
   import ptbf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ptbf_if.cpu link,
   input wire logic req_valid_i,
   input wire logic [PTBF_ADDR_W-1:0] req_addr_i,
   input wire logic [PTBF_CNT_W-1:0] req_count_i,
   input wire logic req_waypoint_i,
   input wire logic req_spec_i,
   input wire logic [PTBF_TAG_W-1:0] req_tag_i,
   input wire logic req_prohibited_i,
   input wire logic req_secure_i,
   input wire logic rsv_valid_i,
   input wire logic rsv_cancel_i,
   input wire logic [PTBF_TAG_W-1:0] rsv_tag_i,
   input wire logic exc_valid_i,
   input wire logic [PTBF_EXC_W-1:0] exc_type_i,
   input wire logic exc_into_prohibited_i,
   input wire logic exc_prohibited_i,
   output logic req_reject_o
);
   logic blk_ok;
   logic blk_valid_reg, blk_valid_next;
   logic [PTBF_ADDR_W-1:0] blk_addr_reg, blk_addr_next;
   logic [PTBF_CNT_W-1:0] blk_count_reg, blk_count_next;
   logic [PTBF_TAG_W-1:0] blk_tag_reg, blk_tag_next;
   logic [PTBF_TAG_W-1:0] res_tag_reg, res_tag_next;
   logic [PTBF_EXC_W-1:0] exc_type_reg, exc_type_next;
   logic [6:0] flag_reg, flag_next;
   logic reject_reg, reject_next;

   // ----------------------------------------------------------------
   // Block forming.
   // ----------------------------------------------------------------
   // An empty block or an exception in the same cycle is refused, so an
   // exception always falls at a block edge and the waypoint, carried
   // as a single flag, can only be the last instruction of the block.
   always_comb begin
      blk_ok = req_valid_i && (req_count_i != '0) && !exc_valid_i;
      blk_valid_next = blk_ok;
      blk_addr_next = blk_ok ? req_addr_i : blk_addr_reg;
      blk_count_next = blk_ok ? req_count_i : blk_count_reg;
      blk_tag_next = blk_ok ? req_tag_i : blk_tag_reg;
      res_tag_next = rsv_tag_i;
      exc_type_next = exc_type_i;
      reject_next = req_valid_i && !blk_ok;
      flag_next = {blk_ok && req_waypoint_i,
                   blk_ok && req_spec_i,
                   blk_ok && req_prohibited_i,
                   blk_ok && req_secure_i,
                   rsv_valid_i, rsv_cancel_i, exc_valid_i};
   end

   // Registers every link output except the exception side flags.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         blk_valid_reg <= 1'b0;
         blk_addr_reg <= PTBF_ADDR_RST;
         blk_count_reg <= PTBF_CNT_ONE;
         blk_tag_reg <= '0;
         res_tag_reg <= '0;
         exc_type_reg <= '0;
         flag_reg <= '0;
         reject_reg <= 1'b0;
      end else begin
         blk_valid_reg <= blk_valid_next;
         blk_addr_reg <= blk_addr_next;
         blk_count_reg <= blk_count_next;
         blk_tag_reg <= blk_tag_next;
         res_tag_reg <= res_tag_next;
         exc_type_reg <= exc_type_next;
         flag_reg <= flag_next;
         reject_reg <= reject_next;
      end
   end

   // Exception side flags travel with the exception pulse.
   logic [1:0] exc_side_reg, exc_side_next;
   always_comb begin
      exc_side_next = {exc_into_prohibited_i, exc_prohibited_i};
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exc_side_reg <= '0;
      end else begin
         exc_side_reg <= exc_side_next;
      end
   end

   assign link.blk_valid = blk_valid_reg;
   assign link.blk_addr = blk_addr_reg;
   assign link.blk_count = blk_count_reg;
   assign link.blk_tag = blk_tag_reg;
   assign link.blk_waypoint = flag_reg[6];
   assign link.blk_spec = flag_reg[5];
   assign link.blk_prohibited = flag_reg[4];
   assign link.blk_secure = flag_reg[3];
   assign link.res_valid = flag_reg[2];
   assign link.res_cancel = flag_reg[1];
   assign link.res_tag = res_tag_reg;
   assign link.exc_valid = flag_reg[0];
   assign link.exc_type = exc_type_reg;
   assign link.exc_into_prohibited = exc_side_reg[1];
   assign link.exc_prohibited = exc_side_reg[0];
   assign req_reject_o = reject_reg;
endmodule : ptbf_cpu_end
`default_nettype wire

// >>> ptbf_trace_end.sv
`timescale 1ns/1ps
`default_nettype none
// Trace unit side: filters blocks and emits trace elements.
module ptbf_trace_end
   import ptbf_pkg::*;
#(
   parameter int TAGS = 16
)(
   input wire logic clk_i,
   input wire logic rst_b_i,
   ptbf_if.trc link,
   input wire logic trace_enable_i,
   input wire logic instruction_view_active_i,
   input wire logic cycle_count_en_i,
   input wire logic secure_debug_en_i,
   input wire logic self_hosted_trace_on_i,
   input wire logic processor_element_warm_reset_i,
   input wire logic [PTBF_ADDR_W-1:0] cmp_lo_i,
   input wire logic [PTBF_ADDR_W-1:0] cmp_hi_i,
   output logic el_valid_o,
   output logic [5:0] el_kind_o,
   output logic [PTBF_ADDR_W-1:0] el_addr_o,
   output logic [PTBF_CNT_W-1:0] el_count_o,
   output logic [PTBF_TAG_W-1:0] el_tag_o,
   output logic [PTBF_EXC_W-1:0] el_exc_o,
   output logic [PTBF_CYC_W-1:0] el_cycles_o,
   output logic el_spec_o,
   output logic cmp_match_o,
   output logic prohibited_o,
   output logic [TAGS-1:0] spec_pending_o
);
   // ----------------------------------------------------------------
   // Input synchronisers for the authentication pins.
   // ----------------------------------------------------------------
   logic [1:0] auth_s1_reg, auth_s2_reg;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         auth_s1_reg <= '0;
         auth_s2_reg <= '0;
      end else begin
         auth_s1_reg <= {secure_debug_en_i, self_hosted_trace_on_i};
         auth_s2_reg <= auth_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Filtering and element selection.
   // ----------------------------------------------------------------
   logic sec_prohib, blk_prohib, exc_traced;
   logic el_valid_reg, el_valid_next;
   logic [5:0] el_kind_reg, el_kind_next;
   logic [PTBF_ADDR_W-1:0] el_addr_reg, el_addr_next;
   logic [PTBF_CNT_W-1:0] el_count_reg, el_count_next;
   logic [PTBF_TAG_W-1:0] el_tag_reg, el_tag_next;
   logic [PTBF_EXC_W-1:0] el_exc_reg, el_exc_next;
   logic [PTBF_CYC_W-1:0] el_cyc_reg, el_cyc_next;
   logic [PTBF_CYC_W-1:0] cyc_reg, cyc_next;
   logic el_spec_reg, el_spec_next;
   logic match_reg, match_next;
   logic prohib_reg, prohib_next;
   logic [TAGS-1:0] pend_reg, pend_next;

   // The warm reset pin only hides exception elements here; it never
   // clears trace state, which only rst_b_i does.
   always_comb begin
      // Secure work is prohibited once both synchronised permissions, secure debug and self-hosted trace, are low.
      sec_prohib = link.blk_secure && !auth_s2_reg[1]
                   && !auth_s2_reg[0];
      blk_prohib = link.blk_prohibited || sec_prohib;
      prohib_next = link.blk_valid ? blk_prohib : prohib_reg;
      // The cycle counter runs whatever the region, restarts when its
      // value is reported, and wraps to zero unreported past its top.
      cyc_next = cycle_count_en_i ? cyc_reg + 1'b1 : cyc_reg;
      el_valid_next = 1'b0;
      el_kind_next = el_kind_reg;
      el_addr_next = el_addr_reg;
      el_count_next = el_count_reg;
      el_tag_next = el_tag_reg;
      el_exc_next = el_exc_reg;
      el_cyc_next = el_cyc_reg;
      el_spec_next = 1'b0;
      pend_next = pend_reg;
      match_next = 1'b0;
      // A traced exception is reported when it leaves traced code, even
      // when it enters a prohibited region; resets in it are hidden.
      exc_traced = link.exc_valid && !link.exc_prohibited
                   && !prohib_reg
                   && !processor_element_warm_reset_i;
      // A resolution always clears its pending bit, but a traced exception in the same cycle takes the element bus.
      if (link.res_valid && pend_reg[link.res_tag]) begin
         pend_next[link.res_tag] = 1'b0;
      end
      if (trace_enable_i && exc_traced) begin
         el_valid_next = 1'b1;
         el_kind_next = PTBF_EL_EXCEPT;
         el_exc_next = link.exc_type;
      end else if (trace_enable_i && link.res_valid
                   && pend_reg[link.res_tag]) begin
         el_valid_next = 1'b1;
         el_kind_next = link.res_cancel ? PTBF_EL_CANCEL
                                        : PTBF_EL_RESOLVE;
         el_tag_next = link.res_tag;
      end else if (trace_enable_i && link.blk_valid && !blk_prohib
                   && instruction_view_active_i) begin
         el_valid_next = 1'b1;
         if (prohib_reg) begin
            // First block after a prohibited region marks the gap.
            el_kind_next = PTBF_EL_TRACE_ON;
            el_cyc_next = cyc_reg;
            cyc_next = PTBF_CYC_RST;
            // The region is left here, so later blocks are plain blocks.
            prohib_next = 1'b0;
         end else begin
            el_kind_next = PTBF_EL_BLOCK;
            el_addr_next = link.blk_addr;
            el_count_next = link.blk_count;
            el_tag_next = link.blk_tag;
            el_spec_next = link.blk_spec;
            el_cyc_next = cyc_reg;
            cyc_next = PTBF_CYC_RST;
            if (link.blk_spec) begin
               pend_next[link.blk_tag] = 1'b1;
            end
         end
      end
      if (link.blk_valid && !blk_prohib) begin
         match_next = ptbf_in_range(link.blk_addr, cmp_lo_i, cmp_hi_i);
      end
      // Nothing about prohibited execution leaks onto the element bus.
      if (link.blk_valid && blk_prohib && !el_valid_next) begin
         el_addr_next = PTBF_ADDR_RST;
         el_count_next = '0;
      end
   end

   // Trace state is cleared only by the trace unit reset.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         el_valid_reg <= 1'b0;
         el_kind_reg <= PTBF_EL_BLOCK;
         el_addr_reg <= PTBF_ADDR_RST;
         el_count_reg <= '0;
         el_tag_reg <= '0;
         el_exc_reg <= '0;
         el_cyc_reg <= PTBF_CYC_RST;
         el_spec_reg <= 1'b0;
         cyc_reg <= PTBF_CYC_RST;
         match_reg <= 1'b0;
         prohib_reg <= 1'b0;
         pend_reg <= '0;
      end else begin
         el_valid_reg <= el_valid_next;
         el_kind_reg <= el_kind_next;
         el_addr_reg <= el_addr_next;
         el_count_reg <= el_count_next;
         el_tag_reg <= el_tag_next;
         el_exc_reg <= el_exc_next;
         el_cyc_reg <= el_cyc_next;
         el_spec_reg <= el_spec_next;
         cyc_reg <= cyc_next;
         match_reg <= match_next;
         prohib_reg <= prohib_next;
         pend_reg <= pend_next;
      end
   end

   assign el_valid_o = el_valid_reg;
   assign el_kind_o = el_kind_reg;
   assign el_addr_o = el_addr_reg;
   assign el_count_o = el_count_reg;
   assign el_tag_o = el_tag_reg;
   assign el_exc_o = el_exc_reg;
   assign el_cycles_o = el_cyc_reg;
   assign el_spec_o = el_spec_reg;
   assign cmp_match_o = match_reg;
   assign prohibited_o = prohib_reg;
   assign spec_pending_o = pend_reg;
endmodule : ptbf_trace_end
`default_nettype wire

// >>> ptbf_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the link and the trace side outputs for block and filter faults.
module ptbf_link_properties
   import ptbf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic blk_valid,
   input wire logic [PTBF_CNT_W-1:0] blk_count,
   input wire logic blk_prohibited,
   input wire logic exc_valid,
   input wire logic exc_prohibited,
   input wire logic el_valid_o,
   input wire logic [5:0] el_kind_o,
   input wire logic cmp_match_o
);
   // ------------------------------------------------------------------
   // Sequences and properties.
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // A block that the processor marks as lying in a hidden region.
   sequence s_hidden_blk;
      blk_valid && blk_prohibited;
   endsequence
   // No block element leaves the trace side.
   sequence s_no_blk_el;
      !(el_valid_o && (el_kind_o == PTBF_EL_BLOCK));
   endsequence

   property p_nonempty;
      blk_valid |-> (blk_count != '0);
   endproperty
   property p_exc_edge;
      exc_valid |-> !blk_valid;
   endproperty
   property p_hidden_quiet;
      s_hidden_blk |-> ##1 s_no_blk_el;
   endproperty
   property p_hidden_nomatch;
      s_hidden_blk |=> !cmp_match_o;
   endproperty
   property p_exc_hidden;
      exc_valid && exc_prohibited |=>
         !(el_valid_o && (el_kind_o == PTBF_EL_EXCEPT));
   endproperty
   property p_match_cause;
      cmp_match_o |-> $past(blk_valid) && !$past(blk_prohibited);
   endproperty
   property p_kind_onehot;
      el_valid_o |-> $onehot(el_kind_o);
   endproperty

   a_p_nonempty: assert property (p_nonempty)
      else $error("Empty block on the link.");
   a_p_exc_edge: assert property (p_exc_edge)
      else $error("Exception inside a block.");
   a_p_hidden_quiet: assert property (p_hidden_quiet)
      else $error("Hidden block was traced.");
   a_p_hidden_nomatch: assert property (p_hidden_nomatch)
      else $error("Comparator matched a hidden block.");
   a_p_exc_hidden: assert property (p_exc_hidden)
      else $error("Hidden exception was traced.");
   a_p_match_cause: assert property (p_match_cause)
      else $error("Comparator match without a visible block.");
   a_p_kind_onehot: assert property (p_kind_onehot)
      else $error("Element kind is not one-hot.");
endmodule : ptbf_link_properties
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the processor end and checks the elements of the trace end.
module testbench
   import ptbf_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic req_valid_i, req_waypoint_i, req_spec_i, req_prohibited_i;
   logic req_secure_i, rsv_valid_i, rsv_cancel_i, exc_valid_i;
   logic exc_into_prohibited_i, exc_prohibited_i, req_reject_o, rej;
   logic [PTBF_ADDR_W-1:0] req_addr_i, el_addr_o;
   logic [PTBF_CNT_W-1:0] req_count_i, el_count_o;
   logic [PTBF_TAG_W-1:0] req_tag_i, rsv_tag_i, el_tag_o;
   logic [PTBF_EXC_W-1:0] exc_type_i, el_exc_o;
   logic trace_en, view_en, cyc_en, sec_en, sh_on, warm;
   logic el_valid_o, el_spec_o, cmp_match_o, prohibited_o;
   logic [5:0] el_kind_o;
   logic [PTBF_CYC_W-1:0] el_cycles_o;
   logic [15:0] spec_pending_o;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   ptbf_if ptbf_if_inst ();
   ptbf_cpu_end ptbf_cpu_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .link(ptbf_if_inst.cpu), .req_valid_i(req_valid_i),
      .req_addr_i(req_addr_i), .req_count_i(req_count_i),
      .req_waypoint_i(req_waypoint_i), .req_spec_i(req_spec_i),
      .req_tag_i(req_tag_i), .req_prohibited_i(req_prohibited_i),
      .req_secure_i(req_secure_i), .rsv_valid_i(rsv_valid_i),
      .rsv_cancel_i(rsv_cancel_i), .rsv_tag_i(rsv_tag_i),
      .exc_valid_i(exc_valid_i), .exc_type_i(exc_type_i),
      .exc_into_prohibited_i(exc_into_prohibited_i),
      .exc_prohibited_i(exc_prohibited_i), .req_reject_o(req_reject_o));
   ptbf_trace_end #(.TAGS(16)) ptbf_trace_end_inst (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .link(ptbf_if_inst.trc),
      .trace_enable_i(trace_en), .instruction_view_active_i(view_en),
      .cycle_count_en_i(cyc_en), .secure_debug_en_i(sec_en),
      .self_hosted_trace_on_i(sh_on),
      .processor_element_warm_reset_i(warm),
      .cmp_lo_i(32'h0000_1000), .cmp_hi_i(32'h0000_1FFF),
      .el_valid_o(el_valid_o), .el_kind_o(el_kind_o),
      .el_addr_o(el_addr_o), .el_count_o(el_count_o), .el_tag_o(el_tag_o),
      .el_exc_o(el_exc_o), .el_cycles_o(el_cycles_o),
      .el_spec_o(el_spec_o), .cmp_match_o(cmp_match_o),
      .prohibited_o(prohibited_o), .spec_pending_o(spec_pending_o));
   ptbf_link_properties ptbf_link_properties_inst (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .blk_valid(ptbf_if_inst.blk_valid),
      .blk_count(ptbf_if_inst.blk_count),
      .blk_prohibited(ptbf_if_inst.blk_prohibited),
      .exc_valid(ptbf_if_inst.exc_valid),
      .exc_prohibited(ptbf_if_inst.exc_prohibited),
      .el_valid_o(el_valid_o), .el_kind_o(el_kind_o),
      .cmp_match_o(cmp_match_o));

   // Free running clock and a hang guard that ends the run.
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         stop_test();
      end
   end

   // Counts one comparison and reports a mismatch.
   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Sends one block request; returns where its element is visible.
   task automatic blk(input logic [31:0] a, input logic [7:0] n,
      input logic wp, sp, input logic [3:0] tg, input logic pr, sc);
      @(negedge clk_i);
      {req_addr_i, req_count_i, req_waypoint_i} = {a, n, wp};
      {req_spec_i, req_tag_i, req_prohibited_i} = {sp, tg, pr};
      {req_secure_i, req_valid_i} = {sc, 1'b1};
      @(negedge clk_i);
      rej = req_reject_o;
      req_valid_i = 1'b0;
      @(negedge clk_i);
   endtask : blk

   // Sends a resolve or cancel, or an exception, one cycle long.
   task automatic side(input logic r, c, input logic [3:0] v,
      input logic into, pr);
      @(negedge clk_i);
      {rsv_valid_i, rsv_cancel_i, rsv_tag_i} = {r, c, v};
      {exc_valid_i, exc_type_i} = {!r, v};
      {exc_into_prohibited_i, exc_prohibited_i} = {into, pr};
      @(negedge clk_i);
      {rsv_valid_i, exc_valid_i} = 2'b00;
      @(negedge clk_i);
   endtask : side

   // Checks that one element of the given kind is out.
   task automatic el(input logic [5:0] k);
      check("el_valid", 32'(el_valid_o), 32'h0000_0001);
      check("el_kind", 32'(el_kind_o), 32'(k));
   endtask : el

   // Ends the run with the counts and the verdict.
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   // Main sequence of scenarios.
   initial begin
      {req_valid_i, req_waypoint_i, req_spec_i, req_prohibited_i} = '0;
      {req_secure_i, rsv_valid_i, rsv_cancel_i, exc_valid_i} = '0;
      {exc_into_prohibited_i, exc_prohibited_i, warm} = '0;
      {req_addr_i, req_count_i, req_tag_i, rsv_tag_i, exc_type_i} = '0;
      {trace_en, view_en, cyc_en, sec_en, sh_on} = 5'b1_1110;
      repeat (6) @(negedge clk_i);
      rst_b_i = 1'b1;
      blk(32'h0000_1000, 8'h04, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
      check("hidden_el", 32'(el_valid_o), 32'h0);
      check("hidden_match", 32'(cmp_match_o), 32'h0);
      check("hidden_prohib", 32'(prohibited_o), 32'h0000_0001);
      blk(32'h0000_1000, 8'h00, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
      check("reject", 32'(rej), 32'h0000_0001);
      check("empty_el", 32'(el_valid_o), 32'h0);
      repeat (20) @(negedge clk_i);
      blk(32'h0000_1000, 8'h03, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
      el(PTBF_EL_TRACE_ON);
      check("cycles", 32'(el_cycles_o >= 16'h0014), 32'h1);
      blk(32'h0000_1010, 8'h05, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
      el(PTBF_EL_BLOCK);
      check("addr", el_addr_o, 32'h0000_1010);
      check("count", 32'(el_count_o), 32'h0000_0005);
      check("match", 32'(cmp_match_o), 32'h0000_0001);
      blk(32'h0000_1020, 8'h02, 1'b0, 1'b1, 4'h3, 1'b0, 1'b0);
      el(PTBF_EL_BLOCK);
      check("spec", 32'(el_spec_o), 32'h0000_0001);
      warm = 1'b1;
      repeat (4) @(negedge clk_i);
      warm = 1'b0;
      check("pend_warm", 32'(spec_pending_o[3]), 32'h0000_0001);
      side(1'b1, 1'b0, 4'h3, 1'b0, 1'b0);
      el(PTBF_EL_RESOLVE);
      check("res_tag", 32'(el_tag_o), 32'h0000_0003);
      check("pend_res", 32'(spec_pending_o[3]), 32'h0);
      blk(32'h0000_3000, 8'h01, 1'b0, 1'b1, 4'h5, 1'b0, 1'b0);
      check("out_match", 32'(cmp_match_o), 32'h0);
      side(1'b1, 1'b1, 4'h5, 1'b0, 1'b0);
      el(PTBF_EL_CANCEL);
      check("can_tag", 32'(el_tag_o), 32'h0000_0005);
      side(1'b0, 1'b0, 4'h6, 1'b1, 1'b0);
      el(PTBF_EL_EXCEPT);
      check("exc_type", 32'(el_exc_o), 32'h0000_0006);
      side(1'b0, 1'b0, 4'h2, 1'b0, 1'b1);
      check("exc_hidden", 32'(el_valid_o), 32'h0);
      blk(32'h0000_1040, 8'h02, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
      el(PTBF_EL_BLOCK);
      sec_en = 1'b0;
      repeat (3) @(negedge clk_i);
      blk(32'h0000_1050, 8'h02, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
      check("sec_hidden", 32'(el_valid_o), 32'h0);
      check("hidden_addr", el_addr_o, 32'h0000_0000);
      blk(32'h0000_1060, 8'h02, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
      el(PTBF_EL_TRACE_ON);
      check("prohib_off", 32'(prohibited_o), 32'h0);
      sh_on = 1'b1;
      repeat (3) @(negedge clk_i);
      blk(32'h0000_1070, 8'h02, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
      el(PTBF_EL_BLOCK);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
